// *** core/vsw_settings_regs.v ***
// Input and output stage settings registers of the video link switch, on AXI4-Lite.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`include "vsw_map.vh"
module vsw_settings_regs #(
  parameter DISCONNECT_CYCLES = `VSW_DISCONNECT_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [15:0] term_connect,
  output reg  [15:0] eq_high,
  output reg  [1:0]  preemph_level,
  output reg  [1:0]  route_source
);

  reg  [7:0]  rx_settings_q;
  reg  [15:0] pulse_sel_q;
  reg  [15:0] eq_sel_q;
  reg  [7:0]  tx_settings_q;
  reg  [3:0]  source_q;
  reg  [31:0] disc_cnt_q;
  reg  [15:0] disc_mask_q;
  reg         aw_held_q;
  reg         w_held_q;
  reg  [4:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  wire [15:0] term_d;
  reg  [31:0] rdata_d;
  reg         rerr_d;
  reg         werr_d;
  wire        aw_take;
  wire        w_take;
  wire        do_write;
  wire        src_write;
  wire        src_change;
  wire        disc_active;
  wire [3:0]  new_source;
  wire        wa_rx;
  wire        wa_pulse1;
  wire        wa_pulse2;
  wire        wa_eq1;
  wire        wa_eq2;
  wire        wa_tx;
  wire        wa_src;
  wire        wa_status;
  wire        ra_rx;
  wire        ra_pulse1;
  wire        ra_pulse2;
  wire        ra_eq1;
  wire        ra_eq2;
  wire        ra_tx;
  wire        ra_src;
  wire        ra_status;
  wire [31:0] status_word;

  assign aw_take   = s_axi_awvalid && s_axi_awready;
  assign w_take    = s_axi_wvalid && s_axi_wready;
  assign do_write  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign src_write = do_write && wa_src && wstrb_q[0];
  assign new_source = wdata_q[3:0];
  // switch detect: only the two low bits choose the quad source.
  assign src_change  = src_write && (new_source[1:0] != source_q[1:0]);
  assign disc_active = (disc_cnt_q != 32'h0000_0000);

  // Write hits decode the address latched when the write address was taken.
  assign wa_rx     = (awaddr_q == `VSW_OFF_RECEIVER_SETTINGS);
  assign wa_pulse1 = (awaddr_q == `VSW_OFF_INPUT_TERM_PULSE_1);
  assign wa_pulse2 = (awaddr_q == `VSW_OFF_INPUT_TERM_PULSE_2);
  assign wa_eq1    = (awaddr_q == `VSW_OFF_RECEIVE_EQUALIZER_1);
  assign wa_eq2    = (awaddr_q == `VSW_OFF_RECEIVE_EQUALIZER_2);
  assign wa_tx     = (awaddr_q == `VSW_OFF_TRANSMITTER_SETTINGS);
  assign wa_src    = (awaddr_q == `VSW_OFF_SOURCE_SELECT);
  assign wa_status = (awaddr_q == `VSW_OFF_TERM_STATUS);

  // Read hits decode the live address, which the master holds until it is taken.
  assign ra_rx     = (s_axi_araddr == `VSW_OFF_RECEIVER_SETTINGS);
  assign ra_pulse1 = (s_axi_araddr == `VSW_OFF_INPUT_TERM_PULSE_1);
  assign ra_pulse2 = (s_axi_araddr == `VSW_OFF_INPUT_TERM_PULSE_2);
  assign ra_eq1    = (s_axi_araddr == `VSW_OFF_RECEIVE_EQUALIZER_1);
  assign ra_eq2    = (s_axi_araddr == `VSW_OFF_RECEIVE_EQUALIZER_2);
  assign ra_tx     = (s_axi_araddr == `VSW_OFF_TRANSMITTER_SETTINGS);
  assign ra_src    = (s_axi_araddr == `VSW_OFF_SOURCE_SELECT);
  assign ra_status = (s_axi_araddr == `VSW_OFF_TERM_STATUS);

  // Bit 16 tells software that a disconnect interval is still running.
  assign status_word = {15'h0000, disc_active, term_d};

  // Write address decode and unmapped answer.
  always @* begin
    werr_d = 1'b0;
    if (wa_rx) begin
      werr_d = 1'b0;
    end else if (wa_pulse1) begin
      werr_d = 1'b0;
    end else if (wa_pulse2) begin
      werr_d = 1'b0;
    end else if (wa_eq1) begin
      werr_d = 1'b0;
    end else if (wa_eq2) begin
      werr_d = 1'b0;
    end else if (wa_tx) begin
      werr_d = 1'b0;
    end else if (wa_src) begin
      werr_d = 1'b0;
    end else if (wa_status) begin
      werr_d = 1'b0;
    end else begin
      werr_d = 1'b1;
    end
  end

  // Write channels: address and data are taken in either order, response after both.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 5'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `VSW_RESP_OKAY;
    end else begin
      // Readies drop the edge after a take, so a held beat is never overwritten.
      s_axi_awready <= !aw_held_q && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= werr_d ? `VSW_RESP_SLVERR : `VSW_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Settings storage; only byte lane 0 carries data.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_settings_q <= `VSW_RST_RECEIVER_SETTINGS;
      pulse_sel_q   <= {`VSW_RST_PULSE, `VSW_RST_PULSE};
      eq_sel_q      <= {`VSW_RST_EQUALIZER, `VSW_RST_EQUALIZER};
      tx_settings_q <= `VSW_RST_TRANSMITTER;
      source_q      <= `VSW_RST_SOURCE;
    end else if (do_write && wstrb_q[0]) begin
      if (wa_rx) begin
        rx_settings_q <= wdata_q[7:0];
      end else if (wa_pulse1) begin
        pulse_sel_q[7:0] <= wdata_q[7:0];
      end else if (wa_pulse2) begin
        pulse_sel_q[15:8] <= wdata_q[7:0];
      end else if (wa_eq1) begin
        eq_sel_q[7:0] <= wdata_q[7:0];
      end else if (wa_eq2) begin
        eq_sel_q[15:8] <= wdata_q[7:0];
      end else if (wa_tx) begin
        tx_settings_q <= wdata_q[7:0];
      end else if (wa_src) begin
        source_q <= new_source;
      end
    end
  end

  // disconnect timer: restarts on every source switch, reloads the channel mask.
  always @(posedge aclk) begin
    if (!aresetn) begin
      disc_cnt_q  <= 32'h0000_0000;
      disc_mask_q <= 16'h0000;
    end else if (src_change) begin
      disc_cnt_q  <= DISCONNECT_CYCLES;
      // pulsed channels: only channels with pulse select set are dropped.
      // The mask is captured here; later pulse-select writes apply at the next switch.
      disc_mask_q <= pulse_sel_q;
    end else if (disc_active) begin
      disc_cnt_q <= disc_cnt_q - 32'h0000_0001;
    end else begin
      disc_mask_q <= 16'h0000;
    end
  end

  // Per-channel termination; bit order follows the register layout (B3..B0, A3..A0, C3..C0, D3..D0).
  genvar ch;
  generate
    for (ch = 0; ch < 16; ch = ch + 1) begin : g_term
      assign term_d[ch] = rx_settings_q[`VSW_TERM_EN_BIT] && !(disc_active && disc_mask_q[ch]);
    end
  endgenerate

  // Drive the analog controls from flip-flops so they never glitch.
  always @(posedge aclk) begin
    if (!aresetn) begin
      term_connect <= 16'h0000;
    end else begin
      term_connect <= term_d;
    end
  end

  // equalization level per channel, same bit order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      eq_high <= 16'h0000;
    end else begin
      eq_high <= eq_sel_q;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      preemph_level <= 2'b00;
    end else begin
      preemph_level <= tx_settings_q[`VSW_PREEMPH_LSB+1:`VSW_PREEMPH_LSB];
    end
  end

  // quad routing from the low two bits.
  always @(posedge aclk) begin
    if (!aresetn) begin
      route_source <= 2'b00;
    end else begin
      route_source <= source_q[1:0];
    end
  end

  // Read decode.
  always @* begin
    rdata_d = 32'h0000_0000;
    rerr_d  = 1'b0;
    if (ra_rx) begin
      rdata_d = {24'h000000, rx_settings_q};
    end else if (ra_pulse1) begin
      rdata_d = {24'h000000, pulse_sel_q[7:0]};
    end else if (ra_pulse2) begin
      rdata_d = {24'h000000, pulse_sel_q[15:8]};
    end else if (ra_eq1) begin
      rdata_d = {24'h000000, eq_sel_q[7:0]};
    end else if (ra_eq2) begin
      rdata_d = {24'h000000, eq_sel_q[15:8]};
    end else if (ra_tx) begin
      rdata_d = {24'h000000, tx_settings_q};
    end else if (ra_src) begin
      rdata_d = {28'h0000000, source_q};
    end else if (ra_status) begin
      rdata_d = status_word;
    end else begin
      rerr_d = 1'b1;
    end
  end

  // Read channel: address taken, data one cycle later, held until rready.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `VSW_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_d;
        s_axi_rresp  <= rerr_d ? `VSW_RESP_SLVERR : `VSW_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** core/vsw_map.vh ***
// Register offsets, field positions, reset values and timing constants of the switch settings.
`ifndef VSW_MAP_VH
`define VSW_MAP_VH
`define VSW_OFF_RECEIVER_SETTINGS     5'h00
`define VSW_OFF_INPUT_TERM_PULSE_1    5'h04
`define VSW_OFF_INPUT_TERM_PULSE_2    5'h08
`define VSW_OFF_RECEIVE_EQUALIZER_1   5'h0c
`define VSW_OFF_RECEIVE_EQUALIZER_2   5'h10
`define VSW_OFF_TRANSMITTER_SETTINGS  5'h14
`define VSW_OFF_SOURCE_SELECT         5'h18
`define VSW_OFF_TERM_STATUS           5'h1c
`define VSW_TERM_EN_BIT               0
`define VSW_PREEMPH_LSB               2
`define VSW_RST_RECEIVER_SETTINGS     8'h01
`define VSW_RST_PULSE                 8'h00
`define VSW_RST_EQUALIZER             8'h00
`define VSW_RST_TRANSMITTER           8'h00
`define VSW_RST_SOURCE                4'h0
`define VSW_DISCONNECT_MS             100
`define VSW_CLK_HZ                    10000000
`define VSW_DISCONNECT_CYCLES         ((`VSW_CLK_HZ / 1000) * `VSW_DISCONNECT_MS)
`define VSW_RESP_OKAY                 2'b00
`define VSW_RESP_SLVERR               2'b10
`endif

// *** sim/vsw_settings_regs_asserts.sv ***
// Bus handshake and settings output checks for the switch settings registers.
module vsw_sr_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [15:0] eq_high,
  input wire logic [1:0]  preemph_level,
  input wire logic [1:0]  route_source
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_drop_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("read address taken twice");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address offered while answering");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write offered while answering");
  b_after_take_a: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
    else $error("write answer without a taken write");
  out_on_write_a: assert property (
    !$stable({eq_high, preemph_level, route_source}) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("setting output changed without a write");
endmodule

bind vsw_settings_regs vsw_sr_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .eq_high, .preemph_level, .route_source);

// *** sim/tb_vsw_settings_regs.sv ***
// Self-checking bench for the switch settings registers.
module tb_vsw_settings_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, preemph_level, route_source;
  logic [15:0] term_connect, eq_high;
  int          n_mismatch = 0;
  int          checks = 0;
  int          v;
  vsw_settings_regs #(.DISCONNECT_CYCLES(20)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .term_connect,
    .eq_high, .preemph_level, .route_source);
  always #50 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] rsp = 2'b00);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, rsp}, {30'h0, s_axi_bresp});
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] rsp = 2'b00);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", {30'h0, rsp}, {30'h0, s_axi_rresp});
    @(posedge aclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_eq();
    wr(5'h0c, 8'h5a);
    wr(5'h10, 8'hc3);
    chk("eq_high", 32'h0000c35a, {16'h0, eq_high});
    rd(5'h10, 32'h000000c3);
  endtask

  task automatic t_levels();
    for (v = 0; v < 4; v++) begin
      wr(5'h14, 8'(v << 2));
      chk("preemph", 32'(v), {30'h0, preemph_level});
    end
    for (v = 3; v >= 0; v--) begin
      wr(5'h18, 8'(v));
      chk("route", 32'(v), {30'h0, route_source});
    end
    chk("term_steady", 32'h0000ffff, {16'h0, term_connect});
  endtask

  task automatic t_pulse();
    wr(5'h04, 8'h0f);
    wr(5'h08, 8'h80);
    wr(5'h18, 8'h01);
    chk("term_drop", 32'h00007ff0, {16'h0, term_connect});
    rd(5'h1c, 32'h00017ff0);
    repeat (8) @(posedge aclk);
    wr(5'h18, 8'h02);
    repeat (12) @(posedge aclk);
    chk("term_restart", 32'h00007ff0, {16'h0, term_connect});
    repeat (12) @(posedge aclk);
    chk("term_back", 32'h0000ffff, {16'h0, term_connect});
  endtask

  task automatic t_global();
    wr(5'h00, 8'h00);
    chk("term_off", 32'h0, {16'h0, term_connect});
    wr(5'h00, 8'h01);
    chk("term_on", 32'h0000ffff, {16'h0, term_connect});
  endtask

  task automatic t_errors();
    wr(5'h1e, 8'h55, 2'b10);
    rd(5'h1e, 32'h0, 2'b10);
    wr(5'h1c, 8'h00);
    rd(5'h1c, 32'h0000ffff);
    s_axi_wstrb <= 4'he;
    wr(5'h14, 8'h00);
    s_axi_wstrb <= 4'hf;
    chk("preemph_strb", 32'h3, {30'h0, preemph_level});
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("term_reset", 32'h0000ffff, {16'h0, term_connect});
    rd(5'h00, 32'h00000001);
    t_eq();
    t_levels();
    t_pulse();
    t_global();
    t_errors();
    wrap_up();
  end

  initial begin
    repeat (3000) @(posedge aclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
